// ---- bench/ebds_mac_model.sv ----
// Model of the MAC FIFO side: rx buffer frames and tx buffer drain.
// Assumes bench commands on clk_sys_i; drain latency given per load.
`timescale 1ns/1ns
`default_nettype none
module ebds_mac_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       rx_push_i,
  input  wire logic       rx_pop_i,
  input  wire logic       tx_load_i,
  input  wire logic [3:0] lat_i,
  output logic            rx_buf_empty_o,
  output logic            frame_in_o,
  output logic            frame_out_o,
  output logic            ctrl_sent_o,
  output logic            tx_empty_o
);
  logic [7:0] cnt_q;
  logic [4:0] drain_q;
  assign rx_buf_empty_o = (cnt_q == 8'h00);
  always_ff @(posedge clk_sys_i) begin
    frame_in_o  <= rx_push_i;
    frame_out_o <= rx_pop_i && cnt_q != 8'h00;
    if (!rst_n_i) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + {7'h0, rx_push_i} - {7'h0, rx_pop_i && cnt_q != 8'h00};
  end
  // slow or prompt drain, then control packet done
  assign tx_empty_o = (drain_q == 5'h0);
  always_ff @(posedge clk_sys_i) begin
    ctrl_sent_o <= (drain_q == 5'h1);
    if (!rst_n_i) drain_q <= 5'h0;
    else if (tx_load_i) drain_q <= {1'b0, lat_i} + 5'h1;
    else if (drain_q != 5'h0) drain_q <= drain_q - 5'h1;
  end
endmodule
`default_nettype wire

// ---- bench/ebds_status_properties.sv ----
// Port-level checker for the buffered frame DMA status block.
// Assumes it is bound to ebds_status and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module ebds_status_chk (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        rx_buf_full_i,
  input wire logic        rx_fifo_move_o,
  input wire logic        rx_desc_not_owned_i,
  input wire logic        rx_stop_on_not_owner_o,
  input wire logic [31:0] tx_descriptor_pointer_i,
  input wire logic        tx_desc_not_owned_i,
  input wire logic        tx_buf_empty_i,
  input wire logic        tx_drain_o,
  input wire logic        tx_dma_run_o,
  input wire logic        stop_on_not_owner_o
);
  import ebds_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic st_rd;
  assign st_rd = hsel_i & htrans_i[1] & hready_i & ~hwrite_i & (haddr_i[15:0] == EBDS_OFS_STATUS);
  a_rx_fifo_move: assert property (rx_fifo_move_o == !rx_buf_full_i)
    else $error("rx fifo move wrong");
  a_tx_drain_on: assert property (tx_drain_o == !tx_buf_empty_i)
    else $error("tx drain wrong");
  a_tx_null_halt: assert property (tx_dma_run_o && tx_descriptor_pointer_i == EBDS_NULL_PTR |=> !tx_dma_run_o)
    else $error("tx run kept on null pointer");
  a_rx_stop_set: assert property (rx_desc_not_owned_i |=> rx_stop_on_not_owner_o)
    else $error("rx stop indication missing");
  a_tx_stop_set: assert property (tx_desc_not_owned_i |=> stop_on_not_owner_o)
    else $error("tx stop indication missing");
  a_more_flag: assert property (st_rd |=> hrdata_o[7] == (hrdata_o[15:8] > 8'h01))
    else $error("additional frame flag wrong");
  a_reserved_zero: assert property (st_rd |=> hrdata_o[31:21] == 11'h000 && !hrdata_o[19] && !hrdata_o[6])
    else $error("reserved status bits set");
  a_tx_empty_bit: assert property (st_rd |=> hrdata_o[20] == $past(tx_buf_empty_i, 2))
    else $error("tx empty flag wrong");
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or error");
endmodule
bind ebds_status ebds_status_chk u_chk (.clk_sys_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .rx_buf_full_i, .rx_fifo_move_o, .rx_desc_not_owned_i, .rx_stop_on_not_owner_o,
  .tx_descriptor_pointer_i, .tx_desc_not_owned_i, .tx_buf_empty_i, .tx_drain_o, .tx_dma_run_o, .stop_on_not_owner_o);
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the buffered frame DMA status block.
// Assumes the MAC model and the bound checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ebds_pkg::*;
  logic        clk, rst_n, hsel, hwrite, hrdy, hresp, rxfull, irq, rx_run, tx_run;
  logic        rx_stop, tx_stop, rxe, txe, fin, fout, csent;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  lat;
  logic [7:0]  ev;
  logic [15:0] haddr, bytes, lenf;
  logic [31:0] hwdata, hrdata, rxp, txp, r;
  int          fails, cmp_count, n, m;
  ebds_mac_model mac (.clk_sys_i(clk), .rst_n_i(rst_n), .rx_push_i(ev[5]), .rx_pop_i(ev[6]), .tx_load_i(ev[7]),
    .lat_i(lat), .rx_buf_empty_o(rxe), .frame_in_o(fin), .frame_out_o(fout), .ctrl_sent_o(csent), .tx_empty_o(txe));
  ebds_status uut (.clk_sys_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i({16'h0, haddr}), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .rx_descriptor_pointer_i(rxp), .rx_frame_written_i(ev[0]), .rx_desc_not_owned_i(ev[1]),
    .rx_frame_end_i(ev[2]), .rx_frame_bytes_i(bytes), .rx_len_valid_i(ev[3]), .rx_len_field_i(lenf),
    .rx_buf_empty_i(rxe), .rx_buf_full_i(rxfull), .rx_buf_frame_in_i(fin), .rx_buf_frame_out_i(fout),
    .rx_dma_run_o(rx_run), .rx_fifo_move_o(), .rx_stop_on_not_owner_o(rx_stop), .tx_descriptor_pointer_i(txp),
    .tx_desc_not_owned_i(ev[4]), .ctrl_pkt_sent_i(csent), .tx_buf_empty_i(txe), .tx_dma_run_o(tx_run),
    .tx_drain_o(), .stop_on_not_owner_o(tx_stop), .irq_o(irq));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] st(input logic [31:0] f, input logic [7:0] c);
    return f | {16'h0, c, c > 8'h01, 7'h0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Idle edge first so event flags have landed before the address edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, r, e);
  endtask
  task automatic fire(input int b);
    ev <= 8'h1 << b;
    @(posedge clk);
    ev <= 8'h0;
    @(posedge clk);
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
  initial begin
    {hsel, hwrite, rxfull, rst_n, htrans, ev, haddr, hwdata, bytes, lenf, lat} = '0;
    hsize = 3'h2;
    void'($urandom(32'ha8df));
    rxp = $urandom | 32'h10;
    txp = $urandom | 32'h10;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(EBDS_OFS_STATUS, 32'h0010_0010, "status reset");
    rd(16'h9000, 32'h0, "unmapped");
    chk("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, EBDS_OFS_MASK, 32'h0007_002f);
    fire(0);
    chk("irq done", {31'h0, irq}, 32'h1);
    rd(EBDS_OFS_STATUS, 32'h0010_0011, "done flag");
    bus(1'b1, EBDS_OFS_STATUS, 32'h1);
    // Write lands on the last bus edge, flags settle after it
    @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      n = i ? $urandom_range(2, 9) : 1;
      rxfull <= 1'(i);
      repeat (n) fire(5);
      rd(EBDS_OFS_STATUS, st(32'h0010_0000, 8'(n)), "frame count");
      repeat (n) fire(6);
      rd(EBDS_OFS_STATUS, st(32'h0010_0010, 8'h0), "count drained");
    end
    m = $urandom_range(64, 1518);
    lenf <= 16'($urandom);
    bytes <= 16'(m);
    bus(1'b1, EBDS_OFS_SIZE, 32'(m));
    fire(2);
    fire(3);
    rd(EBDS_OFS_STATUS, 32'h0010_0030, "size equal");
    bytes <= 16'(m + 1);
    fire(2);
    rd(EBDS_OFS_STATUS, 32'h0010_0038, "oversize");
    rd(EBDS_OFS_SIZE, {lenf, 16'(m)}, "length field");
    bus(1'b1, EBDS_OFS_STATUS, 32'hffff_ffff);
    rd(EBDS_OFS_STATUS, 32'h0010_0010, "all cleared");
    rxp <= 32'h0;
    bus(1'b1, EBDS_OFS_CTRL, 32'h11);
    fire(1);
    chk("rx halt", {30'h0, rx_stop, rx_run}, 32'h2);
    rd(EBDS_OFS_STATUS, 32'h0010_0016, "rx null owner");
    bus(1'b1, EBDS_OFS_CTRL, 32'h4);
    @(posedge clk);
    chk("rx reset", {31'h0, rx_stop}, 32'h0);
    txp <= 32'h0;
    bus(1'b1, EBDS_OFS_CTRL, 32'h22);
    bus(1'b1, EBDS_OFS_STATUS, 32'h0002_0000);
    rd(EBDS_OFS_STATUS, 32'h0012_0016, "tx null kept");
    chk("tx null halt", {31'h0, tx_run}, 32'h0);
    bus(1'b1, EBDS_OFS_CTRL, 32'h28);
    txp <= $urandom | 32'h10;
    bus(1'b1, EBDS_OFS_CTRL, 32'h22);
    rd(EBDS_OFS_STATUS, 32'h0010_0016, "tx null reset");
    chk("tx restart", {31'h0, tx_run}, 32'h1);
    // Zero latency would finish the drain before the busy read
    lat <= 4'($urandom_range(1, 15));
    fire(7);
    rd(EBDS_OFS_STATUS, 32'h0000_0016, "tx busy");
    for (int i = 0; i < 40 && txe !== 1'b1; i++) @(posedge clk);
    fire(4);
    chk("tx halt", {30'h0, tx_stop, tx_run}, 32'h2);
    rd(EBDS_OFS_STATUS, 32'h0015_0016, "ctrl sent owner");
    chk("irq tx", {31'h0, irq}, 32'h1);
    // Mid-run reset: every register back to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset read data", hrdata, 32'h0);
    chk("reset outputs", {27'h0, irq, rx_run, tx_run, rx_stop, tx_stop}, 32'h0);
    rst_n <= 1'b1;
    rd(EBDS_OFS_STATUS, 32'h0010_0010, "status after reset");
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ---- hdl/ebds_pkg.sv ----
// Constants for the buffered frame DMA status block.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
package ebds_pkg;

  // Register byte addresses
  localparam logic [15:0] EBDS_OFS_SIZE   = 16'h9010;
  localparam logic [15:0] EBDS_OFS_STATUS = 16'h9014;
  localparam logic [15:0] EBDS_OFS_CTRL   = 16'h9020;
  localparam logic [15:0] EBDS_OFS_MASK   = 16'h9024;

  // Status field positions
  localparam int EBDS_B_RX_DONE   = 0;
  localparam int EBDS_B_RX_NULL   = 1;
  localparam int EBDS_B_RX_NOWN   = 2;
  localparam int EBDS_B_RX_OVER   = 3;
  localparam int EBDS_B_RX_EMPTY  = 4;
  localparam int EBDS_B_RX_EARLY  = 5;
  localparam int EBDS_B_RX_MORE   = 7;
  localparam int EBDS_B_CNT_LO    = 8;
  localparam int EBDS_B_CTRL_SENT = 16;
  localparam int EBDS_B_TX_NULL   = 17;
  localparam int EBDS_B_TX_NOWN   = 18;
  localparam int EBDS_B_TX_EMPTY  = 20;

  // Control register field positions
  localparam int EBDS_C_RX_EN    = 0;
  localparam int EBDS_C_TX_EN    = 1;
  localparam int EBDS_C_RX_RESET = 2;
  localparam int EBDS_C_TX_RESET = 3;
  localparam int EBDS_C_RX_SKO   = 4;
  localparam int EBDS_C_TX_SKO   = 5;

  // Sticky status bits, the subset software clears by writing one, and the stored control bits
  localparam logic [31:0] EBDS_STICKY_MASK = 32'h0017_003f;
  localparam logic [31:0] EBDS_W1C_MASK    = 32'h0015_003f;
  localparam logic [31:0] EBDS_CTRL_MASK   = 32'h0000_0033;

  // Reset values
  localparam logic [31:0] EBDS_RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] EBDS_RST_SIZE   = 32'h0000_0000;
  localparam logic [31:0] EBDS_RST_CTRL   = 32'h0000_0000;
  localparam logic [31:0] EBDS_RST_MASK   = 32'h0000_0000;
  localparam logic [7:0]  EBDS_RST_COUNT  = 8'h00;

  localparam logic [31:0] EBDS_NULL_PTR = 32'h0000_0000;
  localparam logic [7:0]  EBDS_CNT_MAX  = 8'hff;
  localparam logic [7:0]  EBDS_CNT_ONE  = 8'h01;

endpackage

// ---- hdl/ebds_status.sv ----
// Status, event and interrupt logic of the buffered frame DMA.
// Assumes event pulses and levels from DMA logic on clk_sys_i, AHB-Lite slave.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module ebds_status (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Receive side
  input  wire logic [31:0] rx_descriptor_pointer_i,
  input  wire logic        rx_frame_written_i,
  input  wire logic        rx_desc_not_owned_i,
  input  wire logic        rx_frame_end_i,
  input  wire logic [15:0] rx_frame_bytes_i,
  input  wire logic        rx_len_valid_i,
  input  wire logic [15:0] rx_len_field_i,
  input  wire logic        rx_buf_empty_i,
  input  wire logic        rx_buf_full_i,
  input  wire logic        rx_buf_frame_in_i,
  input  wire logic        rx_buf_frame_out_i,
  output logic             rx_dma_run_o,
  output logic             rx_fifo_move_o,
  output logic             rx_stop_on_not_owner_o,
  // Transmit side
  input  wire logic [31:0] tx_descriptor_pointer_i,
  input  wire logic        tx_desc_not_owned_i,
  input  wire logic        ctrl_pkt_sent_i,
  input  wire logic        tx_buf_empty_i,
  output logic             tx_dma_run_o,
  output logic             tx_drain_o,
  output logic             stop_on_not_owner_o,
  // Interrupt
  output logic             irq_o
);
  import ebds_pkg::*;

  logic [31:0] sticky_q;
  logic [31:0] sticky_d;
  logic [31:0] size_q;
  logic [31:0] ctrl_q;
  logic [31:0] mask_q;
  logic [7:0]  count_q;
  logic        rx_sko_q;
  logic        tx_sko_q;
  logic        wr_pend_q;
  logic [15:0] wr_addr_q;
  logic [31:0] rdata_q;

  logic        addr_ok;
  logic        wr_status;
  logic        wr_size;
  logic        wr_ctrl;
  logic        wr_mask;
  logic        rx_reset;
  logic        tx_reset;
  logic        rx_null;
  logic        tx_null;
  logic        rx_over;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] status_rd;

  // Zero wait states, never an error
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_q;
  assign addr_ok     = hsel_i & htrans_i[1] & hready_i;

  // Word accesses only; hsize is not checked
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 16'h0000;
    end else begin
      wr_pend_q <= addr_ok & hwrite_i;
      wr_addr_q <= haddr_i[15:0];
    end
  end

  assign wr_status = wr_pend_q & (wr_addr_q == EBDS_OFS_STATUS);
  assign wr_size   = wr_pend_q & (wr_addr_q == EBDS_OFS_SIZE);
  assign wr_ctrl   = wr_pend_q & (wr_addr_q == EBDS_OFS_CTRL);
  assign wr_mask   = wr_pend_q & (wr_addr_q == EBDS_OFS_MASK);
  // Reset controls act as one-cycle strobes and are never stored
  assign rx_reset  = wr_ctrl & hwdata_i[EBDS_C_RX_RESET];
  assign tx_reset  = wr_ctrl & hwdata_i[EBDS_C_TX_RESET];

  always_comb begin
    status_rd = sticky_q & EBDS_STICKY_MASK;
    status_rd[EBDS_B_RX_MORE] = (count_q > EBDS_CNT_ONE);
    status_rd[EBDS_B_CNT_LO +: 8] = count_q;
  end

  // Read data registered in the address phase, unmapped reads as zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok & ~hwrite_i) begin
      case (haddr_i[15:0])
        EBDS_OFS_STATUS: rdata_q <= status_rd;
        EBDS_OFS_SIZE:   rdata_q <= size_q;
        EBDS_OFS_CTRL:   rdata_q <= ctrl_q;
        EBDS_OFS_MASK:   rdata_q <= mask_q;
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // rx pointer null while rx DMA runs
  assign rx_null = ctrl_q[EBDS_C_RX_EN] & (rx_descriptor_pointer_i == EBDS_NULL_PTR);
  // tx pointer null while tx DMA runs
  assign tx_null = ctrl_q[EBDS_C_TX_EN] & (tx_descriptor_pointer_i == EBDS_NULL_PTR);
  assign rx_over = rx_frame_end_i & (rx_frame_bytes_i > size_q[15:0]);

  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[EBDS_B_RX_DONE]   = rx_frame_written_i;
    set_vec[EBDS_B_RX_NULL]   = rx_null;
    set_vec[EBDS_B_RX_NOWN]   = rx_desc_not_owned_i;
    set_vec[EBDS_B_RX_OVER]   = rx_over;
    set_vec[EBDS_B_RX_EMPTY]  = rx_buf_empty_i;
    set_vec[EBDS_B_RX_EARLY]  = rx_len_valid_i;
    set_vec[EBDS_B_CTRL_SENT] = ctrl_pkt_sent_i;
    set_vec[EBDS_B_TX_NULL]   = tx_null;
    set_vec[EBDS_B_TX_NOWN]   = tx_desc_not_owned_i;
    set_vec[EBDS_B_TX_EMPTY]  = tx_buf_empty_i;
  end

  always_comb begin
    clr_vec = 32'h0000_0000;
    if (wr_status) begin
      clr_vec = hwdata_i & EBDS_W1C_MASK;
    end
    // empty flag drops once data arrives
    clr_vec[EBDS_B_RX_EMPTY] = clr_vec[EBDS_B_RX_EMPTY] | ~rx_buf_empty_i;
    // empty flag drops once data arrives
    clr_vec[EBDS_B_TX_EMPTY] = clr_vec[EBDS_B_TX_EMPTY] | ~tx_buf_empty_i;
    // only tx reset clears the null flag
    clr_vec[EBDS_B_TX_NULL]  = tx_reset;
  end

  // Set wins over clear so no event is lost
  assign sticky_d = ((sticky_q & ~clr_vec) | set_vec) & EBDS_STICKY_MASK;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sticky_q <= EBDS_RST_STATUS;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      size_q <= EBDS_RST_SIZE;
    end else begin
      if (wr_size) begin
        size_q[15:0] <= hwdata_i[15:0];
      end
      if (rx_len_valid_i) begin
        size_q[31:16] <= rx_len_field_i;
      end
    end
  end

  // frames held in rx buffer, saturating both ways
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || rx_reset) begin
      count_q <= EBDS_RST_COUNT;
    end else if (rx_buf_frame_in_i && !rx_buf_frame_out_i && count_q != EBDS_CNT_MAX) begin
      count_q <= count_q + EBDS_CNT_ONE;
    end else if (rx_buf_frame_out_i && !rx_buf_frame_in_i && count_q != EBDS_RST_COUNT) begin
      count_q <= count_q - EBDS_CNT_ONE;
    end
  end

  // Enables; armed not-owner stops and a tx null pointer halt the engine even against a same-cycle write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= EBDS_RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata_i & EBDS_CTRL_MASK;
      end
      if (rx_reset) begin
        ctrl_q[EBDS_C_RX_EN] <= 1'b0;
      end
      if (tx_reset) begin
        ctrl_q[EBDS_C_TX_EN] <= 1'b0;
      end
      // halt rx when stop on not owner is armed
      if (rx_desc_not_owned_i && ctrl_q[EBDS_C_RX_SKO]) begin
        ctrl_q[EBDS_C_RX_EN] <= 1'b0;
      end
      // halt tx when stop on not owner is armed
      if (tx_desc_not_owned_i && ctrl_q[EBDS_C_TX_SKO]) begin
        ctrl_q[EBDS_C_TX_EN] <= 1'b0;
      end
      if (tx_null) begin
        ctrl_q[EBDS_C_TX_EN] <= 1'b0;
      end
    end
  end

  // stop indication held until rx reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_sko_q <= 1'b0;
    end else if (rx_desc_not_owned_i) begin
      rx_sko_q <= 1'b1;
    end else if (rx_reset) begin
      rx_sko_q <= 1'b0;
    end
  end

  // stop indication held until tx reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_sko_q <= 1'b0;
    end else if (tx_desc_not_owned_i) begin
      tx_sko_q <= 1'b1;
    end else if (tx_reset) begin
      tx_sko_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mask_q <= EBDS_RST_MASK;
    end else if (wr_mask) begin
      mask_q <= hwdata_i & EBDS_STICKY_MASK;
    end
  end

  assign rx_dma_run_o           = ctrl_q[EBDS_C_RX_EN];
  assign tx_dma_run_o           = ctrl_q[EBDS_C_TX_EN];
  assign rx_stop_on_not_owner_o = rx_sko_q;
  assign stop_on_not_owner_o    = tx_sko_q;
  // FIFO to buffer independent of rx enable
  assign rx_fifo_move_o = ~rx_buf_full_i;
  // buffer drains independent of tx enable
  assign tx_drain_o = ~tx_buf_empty_i;

  // sticky done flag holds the level, so a second frame adds no new request
  assign irq_o = |(sticky_q & mask_q);

endmodule

`default_nettype wire
